// [pvcfg_map.svh]
/*
  Address map, reset values and timing counts of the paravirtual PCI
  function's common configuration, doorbell and interrupt cause registers.
  Assumes one 10 MHz clock and word-wide accesses at the offsets below.
*/
`ifndef PVCFG_MAP_SVH
`define PVCFG_MAP_SVH
// Clock period and reset durations, in ns, with cycle counts derived.
`define PVCFG_CLK_NS       100
`define PVCFG_DEV_RST_NS   1000
`define PVCFG_DEV_RST_CYC  ((`PVCFG_DEV_RST_NS + `PVCFG_CLK_NS - 1) / `PVCFG_CLK_NS)
`define PVCFG_Q_RST_NS     500
`define PVCFG_Q_RST_CYC    ((`PVCFG_Q_RST_NS + `PVCFG_CLK_NS - 1) / `PVCFG_CLK_NS)
// Queue counts and management queue window.
`define PVCFG_TOT_Q        4
`define PVCFG_NUM_Q        16'h0003
`define PVCFG_MGMT_IDX     16'h0003
`define PVCFG_MGMT_NUM     16'h0001
`define PVCFG_Q_SIZE_MAX   16'h0100
// Offered features and the management queue feature bit.
`define PVCFG_OFFERED      64'h0000_0200_0000_0001
`define PVCFG_MGMT_BIT     41
// Structure placement inside the BAR and doorbell geometry.
`define PVCFG_CC_OFF       12'h000
`define PVCFG_DB_OFF       12'h100
`define PVCFG_DB_STRIDE    32'h0000_0004
`define PVCFG_DB_LEN       32'h0000_000E
// Register offsets.
`define PVCFG_A_DFSEL      12'h000
`define PVCFG_A_DFEAT      12'h004
`define PVCFG_A_GFSEL      12'h008
`define PVCFG_A_GFEAT      12'h00C
`define PVCFG_A_NUMQ       12'h010
`define PVCFG_A_DSTAT      12'h014
`define PVCFG_A_CGEN       12'h018
`define PVCFG_A_QSEL       12'h01C
`define PVCFG_A_QSIZE      12'h020
`define PVCFG_A_QEN        12'h024
`define PVCFG_A_QSLOT      12'h028
`define PVCFG_A_QRST       12'h02C
`define PVCFG_A_MGIDX      12'h030
`define PVCFG_A_MGNUM      12'h034
`define PVCFG_A_DBSTRIDE   12'h038
`define PVCFG_A_DBOFF      12'h03C
`define PVCFG_A_DBLEN      12'h040
`define PVCFG_A_ISR        12'h080
`endif

// [pvcfg_pkg.sv]
/*
  Types shared by the paravirtual configuration register block.
  Assumes the address map header is compiled alongside.
*/
`default_nettype none
package pvcfg_pkg;
  // One register access from the PCI function.
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pvcfg_acc_t;
  // Device reset sequencer states.
  typedef enum logic {PVCFG_RUN, PVCFG_RST} pvcfg_dev_t;
  // Interrupt cause byte layout.
  typedef struct packed {
    logic [5:0] rsvd;
    logic       cfg;
    logic       queue;
  } pvcfg_isr_t;
endpackage
`default_nettype wire

// [pvcfg_regs.sv]
/*
  Common configuration, doorbell and interrupt cause registers of a
  paravirtual PCI function. Assumes the PCI function hands over one
  access per request pulse on the same clock, and that queue logic
  raises event pulses on the same clock.
*/
// What this block does
// [R1] Offered-feature window shows bits select*32 onward, zero beyond defined features.
// [R2] Accepted-feature window reads back written bits that are also offered.
// [R3] Generation counter bumps on a config read after a pending change.
// [R4] Writing zero to state byte resets device; reads zero once done.
// [R5] Queue restart write of 1 reads 1 until done, then both fields 0.
// [R6] Restart field reads zero once the queue is switched on.
// [R7] Queue depth reads zero for a missing selected queue.
// [R8] Queue depth is always zero or a power of two.
// [R9] Management index not below queue count; count fits below 0x10000.
// [R10] Driver never writes read-only fields; such writes are ignored.
// [R11] Driver writes only power-of-two queue depths.
// [R12] Driver programs queue fields first and never writes queue on 0.
// [R13] Driver polls state byte for zero before reinitialising.
// [R14] Driver waits for restart field 0 before reprogramming the queue.
// [R15] Driver uses only management indices inside the offered window.
// [R16] Doorbell address is offset plus slot times stride.
// [R17] Without payload, offset 2-byte aligned, stride zero or even power.
// [R18] Doorbell length covers every slot times stride plus 2.
// [R19] With payload, stride multiple of four and offset 4-byte aligned.
// [R20] Cause byte: bit 0 queue, bit 1 configuration change.
// [R21] Reading the cause byte clears it and drops the legacy interrupt.
// [R22] Common configuration sits at a 4-byte aligned offset.
// [R23] Cause flag is set before the matching notification leaves.
// [R24] Interrupt status is OR of cause bits when MSI-X is off.
// [R25] Queue on field: 1 enabled, 0 disabled; disabled queues do nothing.
// [R26] Per-queue fields are banked and reached through the selector.
`include "pvcfg_map.svh"
`default_nettype none
module pvcfg_regs (
  // Clock and reset.
  input  wire logic                    i_mclk,
  input  wire logic                    i_arst_n,
  // Register access from the PCI function.
  input  wire logic                    i_acc_req,
  input  wire pvcfg_pkg::pvcfg_acc_t   i_acc,
  output logic                         o_ack,
  output logic [31:0]                  o_rdata,
  // Device-specific configuration tracking.
  input  wire logic                    i_cfg_changed,
  input  wire logic                    i_cfg_read,
  // Events from the queue logic and PCI interrupt controls.
  input  wire logic                    i_queue_event,
  input  wire logic                    i_cfg_event,
  input  wire logic                    i_msix_on,
  input  wire logic                    i_intx_mask,
  // Interrupt and notification outputs.
  output logic                         o_irq_status,
  output logic                         o_intx,
  output logic                         o_queue_notify,
  output logic                         o_cfg_notify,
  // Queue control outputs.
  output logic [`PVCFG_TOT_Q-1:0]      o_queue_on,
  output logic [`PVCFG_TOT_Q-1:0]      o_doorbell,
  output logic                         o_dev_resetting
);
  localparam int TQ = `PVCFG_TOT_Q;

  logic [31:0]           dfsel;
  logic [31:0]           gfsel;
  logic [63:0]           drv_feat;
  logic [7:0]            status;
  logic [7:0]            cgen;
  logic                  cpend;
  logic [15:0]           qsel;
  pvcfg_pkg::pvcfg_dev_t dev_state;
  logic [3:0]            dev_cnt;
  pvcfg_pkg::pvcfg_isr_t isr;
  pvcfg_pkg::pvcfg_isr_t next_isr;
  logic [15:0]           q_size [TQ];
  logic [TQ-1:0]         q_on;
  logic [TQ-1:0]         q_busy;
  logic [TQ-1:0]         db_hit;
  logic [31:0]           rd_data;

  // Access decode.
  wire        wr_go   = i_acc_req & i_acc.wr;
  wire        rd_go   = i_acc_req & ~i_acc.wr;
  wire        dev_run = (dev_state == pvcfg_pkg::PVCFG_RUN);
  wire        dev_done = (dev_state == pvcfg_pkg::PVCFG_RST) && (dev_cnt == 4'h0);
  wire        wr_dstat = wr_go && (i_acc.addr == `PVCFG_A_DSTAT) && dev_run;
  wire        wr_zero  = wr_dstat && (i_acc.wdata[7:0] == 8'h00);
  wire        sel_ok   = (qsel < 16'(TQ));
  wire [1:0]  sel_idx  = qsel[1:0];
  wire        wr_qsize = wr_go && (i_acc.addr == `PVCFG_A_QSIZE) && sel_ok && dev_run;
  wire        wr_qen   = wr_go && (i_acc.addr == `PVCFG_A_QEN) && sel_ok && dev_run;
  wire        wr_qrst  = wr_go && (i_acc.addr == `PVCFG_A_QRST) && sel_ok && dev_run;
  wire        isr_rd   = rd_go && (i_acc.addr == `PVCFG_A_ISR);
  wire        mgmt_neg = drv_feat[`PVCFG_MGMT_BIT];
  wire [15:0] wsz      = i_acc.wdata[15:0];

  // A depth is taken only as a power of two within the maximum.
  wire wsz_ok = (i_acc.wdata[31:16] == 16'h0000) && (wsz != 16'h0000) &&
                ((wsz & (wsz - 16'h0001)) == 16'h0000) &&
                (wsz <= `PVCFG_Q_SIZE_MAX); // R8

  // Feature windows; selectors past the defined bits show zero.
  wire [63:0] offered = `PVCFG_OFFERED;
  wire [31:0] dfeat_win = (dfsel == 32'h0000_0000) ? offered[31:0] :
                          (dfsel == 32'h0000_0001) ? offered[63:32] :
                          32'h0000_0000; // R1
  wire [31:0] gfeat_win = (gfsel == 32'h0000_0000) ? drv_feat[31:0] :
                          (gfsel == 32'h0000_0001) ? drv_feat[63:32] :
                          32'h0000_0000; // R2

  // Selected queue view; a missing queue shows depth zero.
  wire [15:0] sel_size = sel_ok ? q_size[sel_idx] : 16'h0000; // R7 R26
  wire        sel_on   = sel_ok & q_on[sel_idx];
  wire        sel_busy = sel_ok & q_busy[sel_idx];

  // Read selection; unmapped offsets and read-only writes return nothing.
  always_comb begin
    case (i_acc.addr) // R22
      `PVCFG_A_DFSEL:    rd_data = dfsel;
      `PVCFG_A_DFEAT:    rd_data = dfeat_win;
      `PVCFG_A_GFSEL:    rd_data = gfsel;
      `PVCFG_A_GFEAT:    rd_data = gfeat_win;
      `PVCFG_A_NUMQ:     rd_data = {16'h0000, `PVCFG_NUM_Q};
      `PVCFG_A_DSTAT:    rd_data = {24'h00_0000, status};
      `PVCFG_A_CGEN:     rd_data = {24'h00_0000, cgen};
      `PVCFG_A_QSEL:     rd_data = {16'h0000, qsel};
      `PVCFG_A_QSIZE:    rd_data = {16'h0000, sel_size};
      `PVCFG_A_QEN:      rd_data = {31'h0000_0000, sel_on};
      `PVCFG_A_QSLOT:    rd_data = sel_ok ? {30'h0000_0000, sel_idx} : 32'h0000_0000;
      `PVCFG_A_QRST:     rd_data = {31'h0000_0000, sel_busy}; // R5 R6
      `PVCFG_A_MGIDX:    rd_data = mgmt_neg ? {16'h0000, `PVCFG_MGMT_IDX} : 32'h0000_0000; // R9
      `PVCFG_A_MGNUM:    rd_data = mgmt_neg ? {16'h0000, `PVCFG_MGMT_NUM} : 32'h0000_0000; // R9
      `PVCFG_A_DBSTRIDE: rd_data = `PVCFG_DB_STRIDE; // R17 R19
      `PVCFG_A_DBOFF:    rd_data = {20'h0_0000, `PVCFG_DB_OFF}; // R17 R19
      `PVCFG_A_DBLEN:    rd_data = `PVCFG_DB_LEN; // R18
      `PVCFG_A_ISR:      rd_data = {24'h00_0000, isr};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // Every request is answered on the next edge.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_ack   <= i_acc_req;
      o_rdata <= rd_go ? rd_data : 32'h0000_0000;
    end
  end

  // Feature selectors and accepted features; unoffered bits are dropped.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dfsel    <= 32'h0000_0000;
      gfsel    <= 32'h0000_0000;
      drv_feat <= 64'h0000_0000_0000_0000;
    end else if (dev_done) begin
      drv_feat <= 64'h0000_0000_0000_0000;
    end else if (wr_go && dev_run) begin
      if (i_acc.addr == `PVCFG_A_DFSEL) dfsel <= i_acc.wdata;
      if (i_acc.addr == `PVCFG_A_GFSEL) gfsel <= i_acc.wdata;
      if (i_acc.addr == `PVCFG_A_GFEAT && gfsel == 32'h0000_0000)
        drv_feat[31:0] <= i_acc.wdata & offered[31:0]; // R2
      if (i_acc.addr == `PVCFG_A_GFEAT && gfsel == 32'h0000_0001)
        drv_feat[63:32] <= i_acc.wdata & offered[63:32]; // R2
    end
  end

  // Pending change flag; a new change in the read cycle stays pending.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cpend <= 1'b0;
      cgen  <= 8'h00;
    end else begin
      cpend <= i_cfg_changed | (cpend & ~i_cfg_read); // R3
      if (i_cfg_read && cpend) cgen <= cgen + 8'h01; // R3
    end
  end

  // Device reset sequencer; the state byte holds its old value until done.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_state <= pvcfg_pkg::PVCFG_RUN;
      dev_cnt   <= 4'h0;
      status    <= 8'h00;
    end else begin
      case (dev_state)
        pvcfg_pkg::PVCFG_RUN: begin
          if (wr_zero) begin
            dev_state <= pvcfg_pkg::PVCFG_RST; // R4
            dev_cnt   <= 4'(`PVCFG_DEV_RST_CYC - 1);
          end else if (wr_dstat) begin
            status <= i_acc.wdata[7:0];
          end
        end
        pvcfg_pkg::PVCFG_RST: begin
          dev_cnt <= dev_cnt - 4'h1;
          if (dev_done) begin
            dev_state <= pvcfg_pkg::PVCFG_RUN;
            status    <= 8'h00; // R4
          end
        end
        default: dev_state <= pvcfg_pkg::PVCFG_RUN;
      endcase
    end
  end

  // Queue selector, cleared by device reset.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      qsel <= 16'h0000;
    end else if (dev_done) begin
      qsel <= 16'h0000;
    end else if (wr_go && dev_run && i_acc.addr == `PVCFG_A_QSEL) begin
      qsel <= i_acc.wdata[15:0]; // R26
    end
  end

  // Banked per-queue state and doorbell decode.
  for (genvar q = 0; q < TQ; q++) begin : g_q
    localparam logic [11:0] DB_ADDR = 12'(`PVCFG_DB_OFF + q * `PVCFG_DB_STRIDE);
    logic [3:0] cnt;
    wire        mine = (sel_idx == 2'(q));
    assign q_busy[q] = (cnt != 4'h0);
    assign db_hit[q] = wr_go && (i_acc.addr == DB_ADDR); // R16

    // Depth, on bit and restart countdown of one queue.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        q_size[q] <= `PVCFG_Q_SIZE_MAX;
        q_on[q]   <= 1'b0;
        cnt       <= 4'h0;
      end else if (dev_done) begin
        q_size[q] <= `PVCFG_Q_SIZE_MAX; // R4
        q_on[q]   <= 1'b0; // R4
        cnt       <= 4'h0; // R4
      end else begin
        if (q_busy[q]) cnt <= cnt - 4'h1; // R5
        if (wr_qsize && mine && wsz_ok) q_size[q] <= wsz; // R8 R26
        if (wr_qen && mine && i_acc.wdata[0] && !q_busy[q]) q_on[q] <= 1'b1; // R25
        if (wr_qrst && mine && i_acc.wdata[0]) begin
          q_on[q] <= 1'b0; // R5
          cnt     <= 4'(`PVCFG_Q_RST_CYC); // R5
        end
      end
    end
  end

  // Cause byte: events set bits, a read clears, a set in that cycle survives.
  always_comb begin
    next_isr       = isr_rd ? 8'h00 : isr; // R21
    next_isr.queue = next_isr.queue | i_queue_event; // R20
    next_isr.cfg   = next_isr.cfg | i_cfg_event; // R20
    next_isr.rsvd  = 6'h00;
  end

  // Interrupt, notification and queue outputs.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      isr             <= 8'h00;
      o_irq_status    <= 1'b0;
      o_intx          <= 1'b0;
      o_queue_notify  <= 1'b0;
      o_cfg_notify    <= 1'b0;
      o_queue_on      <= '0;
      o_doorbell      <= '0;
      o_dev_resetting <= 1'b0;
    end else begin
      isr             <= next_isr;
      o_irq_status    <= (|next_isr) & ~i_msix_on; // R24
      o_intx          <= (|next_isr) & ~i_msix_on & ~i_intx_mask; // R21 R24
      o_queue_notify  <= i_queue_event; // R23
      o_cfg_notify    <= i_cfg_event; // R23
      o_queue_on      <= q_on; // R25
      o_doorbell      <= db_hit & q_on; // R25
      o_dev_resetting <= ~dev_run;
    end
  end

  // Checks.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_dev_zero;
    wr_zero;
  endsequence
  sequence s_dev_clean;
    ##[1:12] (dev_run && status == 8'h00 && q_on == '0);
  endsequence
  logic [1:0] chk_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) chk_q <= 2'b00;
    else if (wr_qrst) chk_q <= sel_idx;
  end

  feat_window_a: assert property (rd_go && i_acc.addr == `PVCFG_A_DFEAT && dfsel > 32'h0000_0001 // R1
    |=> o_ack && o_rdata == 32'h0000_0000) else $error("feature window beyond 63 not zero");
  gen_bump_a: assert property (i_cfg_read && cpend |=> cgen == $past(cgen) + 8'h01) // R3
    else $error("generation counter did not change");
  dev_reset_a: assert property (s_dev_zero |-> s_dev_clean) // R4
    else $error("device reset did not complete");
  qrst_seq_a: assert property (wr_qrst && i_acc.wdata[0] && !dev_done // R5
    |=> (q_busy[chk_q] && !q_on[chk_q]) [*5] ##1 (!q_busy[chk_q] && !q_on[chk_q]))
    else $error("queue restart sequence wrong");
  qsize_pow2_a: assert property ($onehot0(sel_size)) // R8
    else $error("queue depth not a power of two");
  qsize_absent_a: assert property (rd_go && i_acc.addr == `PVCFG_A_QSIZE && !sel_ok // R7
    |=> o_rdata == 32'h0000_0000) else $error("missing queue shows nonzero depth");
  mgmt_window_a: assert property (rd_go && i_acc.addr == `PVCFG_A_MGIDX && mgmt_neg // R9
    |=> o_rdata[15:0] >= `PVCFG_NUM_Q &&
        17'(`PVCFG_MGMT_NUM) <= 17'h1_0000 - 17'(o_rdata[15:0]))
    else $error("management queue window out of range");
  isr_clear_a: assert property (isr_rd && !i_queue_event && !i_cfg_event // R21
    |=> isr == 8'h00 && !o_intx) else $error("cause byte not cleared by read");
  cause_first_a: assert property (o_cfg_notify |-> isr.cfg || $past(isr_rd)) // R23
    else $error("notification without cause flag");
  irq_or_a: assert property (##1 (o_irq_status == ((|isr) && !$past(i_msix_on)))) // R24
    else $error("interrupt status differs from cause bits");
endmodule
`default_nettype wire

// [pvcfg_host.sv]
/*
  Host driver model that issues register accesses to the function.
  Assumes one clock shared with the register block.
*/
`include "pvcfg_map.svh"
`default_nettype none
module pvcfg_host (
  // Clock.
  input  wire logic                  i_mclk,
  // Access path to the register block.
  output var pvcfg_pkg::pvcfg_acc_t  o_acc,
  output var logic                   o_acc_req,
  input  wire logic                  i_ack,
  input  wire logic [31:0]           i_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Request lines start idle so nothing is taken during reset.
  initial begin
    o_acc_req = 1'b0;
    o_acc = '0;
  end

  // One access: a single request pulse, then a bounded wait for the answer.
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = '0;
    @(posedge i_mclk);
    o_acc_req <= 1'b1;
    o_acc <= '{wr: wr, addr: a, wdata: d};
    @(posedge i_mclk);
    o_acc_req <= 1'b0;
    o_acc <= '{wr: 1'b0, addr: ~a, wdata: ~d};  // Released lines do not keep old data.
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_mclk);
      ok = (i_ack === 1'b1);
      q = i_rdata;
    end
  endtask

  // Reads one register until it shows the wanted value, with a bounded count.
  task automatic poll(input logic [11:0] a, input logic [31:0] want, output logic ok);
    logic [31:0] q;
    logic        got;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      acc(1'b0, a, '0, q, got);
      ok = got && (q === want);
    end
  endtask

  // Rings a queue's doorbell at the address derived from its slot and the stride.
  task automatic ring(input logic [31:0] qi, output logic ok);
    logic [31:0] slot, mul, base, q;
    logic [4:0]  g;
    acc(1'b1, `PVCFG_A_QSEL, qi, q, g[0]);
    acc(1'b0, `PVCFG_A_QSLOT, '0, slot, g[1]);
    acc(1'b0, `PVCFG_A_DBSTRIDE, '0, mul, g[2]);
    acc(1'b0, `PVCFG_A_DBOFF, '0, base, g[3]);
    acc(1'b1, 12'(base + slot * mul), '0, q, g[4]);
    ok = &g;
  endtask
endmodule
`default_nettype wire

// [pvcfg_regs_tb.sv]
/*
  Self-checking bench for the paravirtual configuration registers.
  Assumes the host model drives all register accesses on the same clock.
*/
`include "pvcfg_map.svh"
`default_nettype none
module pvcfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] OFF = `PVCFG_OFFERED;
  logic                   clk, rst_n, cfg_chg, cfg_rd, q_ev, c_ev, msix, imask;
  logic                   ack, irq, intx, qn, cn, dres, req, res_seen, ok;
  logic [31:0]            rdata;
  logic [3:0]             qon, db, db_seen;
  pvcfg_pkg::pvcfg_acc_t  acc;
  int                     fail_count, n_checks;

  pvcfg_host host (.i_mclk(clk), .o_acc(acc), .o_acc_req(req), .i_ack(ack),
                   .i_rdata(rdata));
  pvcfg_regs DUT (.i_mclk(clk), .i_arst_n(rst_n), .i_acc_req(req), .i_acc(acc),
    .o_ack(ack), .o_rdata(rdata), .i_cfg_changed(cfg_chg), .i_cfg_read(cfg_rd),
    .i_queue_event(q_ev), .i_cfg_event(c_ev), .i_msix_on(msix), .i_intx_mask(imask),
    .o_irq_status(irq), .o_intx(intx), .o_queue_notify(qn), .o_cfg_notify(cn),
    .o_queue_on(qon), .o_doorbell(db), .o_dev_resetting(dres));

  // Clock at 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Collects doorbell pulses and reset activity between checks.
  always @(posedge clk) begin
    db_seen <= db_seen | db;
    res_seen <= res_seen | dres;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares register words and single flags.
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Register reads and writes through the host, stopping if no answer comes.
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    host.acc(1'b0, a, '0, q, ok);
    if (!ok) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.acc(1'b1, a, d, q, ok);
    if (!ok) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // Pulses {cfg_rd, cfg_chg, c_ev, q_ev} for one cycle, then waits to mid-cycle.
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    {cfg_rd, cfg_chg, c_ev, q_ev} <= v;
    @(posedge clk);
    {cfg_rd, cfg_chg, c_ev, q_ev} <= 4'h0;
    @(negedge clk);
  endtask

  function automatic logic pow2(input logic [31:0] x);
    return x != 0 && (x & (x - 1)) == 0;
  endfunction

  // Feature windows and management queue limits.
  task automatic t_feat;
    logic [31:0] q, ix;
    for (int s = 0; s < 3; s++) begin
      wr(`PVCFG_A_DFSEL, s);
      rd(`PVCFG_A_DFEAT, q);
      chk_word("offered", (s < 2) ? OFF[s*32 +: 32] : 32'h0000_0000, q);
    end
    wr(`PVCFG_A_GFSEL, 32'h0000_0001);
    wr(`PVCFG_A_GFEAT, 32'hFFFF_FFFF);
    rd(`PVCFG_A_GFEAT, q);
    chk_word("accepted", OFF[63:32], q & OFF[63:32]);
    rd(`PVCFG_A_MGIDX, ix);
    chk_bit("mgmt index", 1'b1, ix >= 32'(`PVCFG_NUM_Q));
    rd(`PVCFG_A_MGNUM, q);
    chk_bit("mgmt count", 1'b1, q <= 32'h0001_0000 - ix && q != 0);
    wr(`PVCFG_A_QSEL, ix);
    rd(`PVCFG_A_QSIZE, q);
    chk_word("mgmt depth", 32'(`PVCFG_Q_SIZE_MAX), q);
    $display("test features done");
  endtask

  // Generation counter moves after a read of changed configuration.
  task automatic t_gen;
    logic [31:0] g0, g1;
    rd(`PVCFG_A_CGEN, g0);
    pulse(4'b0100);
    pulse(4'b1000);
    rd(`PVCFG_A_CGEN, g1);
    chk_bit("generation moved", 1'b1, g1 !== g0);
    $display("test generation done");
  endtask

  // Queue depth, banking, enable and per-queue restart.
  task automatic t_queue;
    logic [31:0] q;
    wr(`PVCFG_A_QSEL, 32'h0000_0004);
    rd(`PVCFG_A_QSIZE, q);
    chk_word("missing depth", 32'h0000_0000, q);
    wr(`PVCFG_A_QSEL, 32'h0000_0001);
    rd(`PVCFG_A_QSIZE, q);
    chk_bit("depth pow2", 1'b1, pow2(q));
    wr(`PVCFG_A_QSIZE, 32'h0000_0040);
    wr(`PVCFG_A_QSEL, 32'h0000_0000);
    rd(`PVCFG_A_QSIZE, q);
    chk_word("bank depth", 32'(`PVCFG_Q_SIZE_MAX), q);
    wr(`PVCFG_A_QSEL, 32'h0000_0001);
    rd(`PVCFG_A_QSIZE, q);
    chk_word("set depth", 32'h0000_0040, q);
    wr(`PVCFG_A_QEN, 32'h0000_0001);
    rd(`PVCFG_A_QEN, q);
    chk_word("queue on", 32'h0000_0001, q);
    chk_word("queue on pins", 32'h0000_0002, {28'h0, qon});
    rd(`PVCFG_A_QRST, q);
    chk_word("restart idle", 32'h0000_0000, q);
    wr(`PVCFG_A_QRST, 32'h0000_0001);
    rd(`PVCFG_A_QRST, q);
    chk_word("restart busy", 32'h0000_0001, q);
    host.poll(`PVCFG_A_QRST, 32'h0000_0000, ok);
    chk_bit("restart done", 1'b1, ok);
    rd(`PVCFG_A_QEN, q);
    chk_word("queue off", 32'h0000_0000, q);
    wr(`PVCFG_A_QEN, 32'h0000_0001);
    $display("test queue done");
  endtask

  // Doorbell geometry and doorbell pulses to on and off queues.
  task automatic t_db;
    logic [31:0] st, q;
    rd(`PVCFG_A_DBSTRIDE, st);
    chk_bit("stride", 1'b1, st == 0 || (pow2(st) && !st[0]));
    rd(`PVCFG_A_DBOFF, q);
    chk_bit("db offset", 1'b0, q[0]);
    rd(`PVCFG_A_DBLEN, q);
    chk_bit("db length", 1'b1, q >= 2 && q >= (`PVCFG_TOT_Q - 1) * st + 2);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      db_seen = 4'h0;
      host.ring(k, ok);
      @(negedge clk);
      chk_word("doorbell", {30'h0, ok && k == 1, 1'b0}, {28'h0, db_seen});
    end
    $display("test doorbell done");
  endtask

  // Cause byte, interrupt status, legacy line and masking.
  task automatic t_irq;
    logic [31:0] q;
    pulse(4'b0001);
    chk_bit("queue notify", 1'b1, qn);
    chk_bit("irq status", 1'b1, irq);
    pulse(4'b0010);
    chk_bit("cfg notify", 1'b1, cn);
    chk_bit("intx", 1'b1, intx);
    rd(`PVCFG_A_ISR, q);
    chk_word("cause", 32'h0000_0003, q);
    @(negedge clk);
    chk_bit("intx cleared", 1'b0, intx);
    chk_bit("status cleared", 1'b0, irq);
    rd(`PVCFG_A_ISR, q);
    chk_word("cause cleared", 32'h0000_0000, q);
    @(posedge clk);
    imask <= 1'b1;
    pulse(4'b0010);
    chk_bit("masked intx", 1'b0, intx);
    chk_bit("masked status", 1'b1, irq);
    rd(`PVCFG_A_ISR, q);
    chk_word("cfg cause", 32'h0000_0002, q);
    imask <= 1'b0;
    msix  <= 1'b1;
    pulse(4'b0001);
    chk_bit("msix status", 1'b0, irq);
    chk_bit("msix intx", 1'b0, intx);
    chk_bit("msix notify", 1'b1, qn);
    rd(`PVCFG_A_ISR, q);
    chk_word("msix cause", 32'h0000_0001, q);
    msix <= 1'b0;
    $display("test interrupt done");
  endtask

  // Device reset through the state byte.
  task automatic t_reset;
    logic [31:0] q;
    wr(`PVCFG_A_DSTAT, 32'h0000_000F);
    rd(`PVCFG_A_DSTAT, q);
    chk_word("state", 32'h0000_000F, q);
    @(negedge clk);
    res_seen = 1'b0;
    wr(`PVCFG_A_DSTAT, 32'h0000_0000);
    host.poll(`PVCFG_A_DSTAT, 32'h0000_0000, ok);
    chk_bit("reset done", 1'b1, ok && res_seen);
    chk_word("queues off", 32'h0000_0000, {28'h0, qon});
    wr(`PVCFG_A_QSEL, 32'h0000_0001);
    rd(`PVCFG_A_QRST, q);
    chk_word("restart after reset", 32'h0000_0000, q);
    rd(12'h0FC, q);
    chk_word("unmapped", 32'h0000_0000, q);
    $display("test reset done");
  endtask

  // Reset, the scenarios in order, and the verdict.
  initial begin
    rst_n = 1'b0;
    {cfg_rd, cfg_chg, c_ev, q_ev} = 4'h0;
    msix = 1'b0;
    imask = 1'b0;
    fail_count = 0;
    n_checks = 0;
    db_seen = 4'h0;
    res_seen = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_feat();
    t_gen();
    t_queue();
    t_db();
    t_irq();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
